/* File: logic/essc_regs.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit Avalon-MM word addressing by byte address
// Notes: included by its bare name
`ifndef ESSC_REGS_SVH
`define ESSC_REGS_SVH

// register byte offsets
`define ESSC_OFF_UWORD 4'h0
`define ESSC_OFF_OPBUF 4'h4
`define ESSC_OFF_PHASE 4'h8
`define ESSC_OFF_FLAGS 4'hC

// microword field positions
`define ESSC_UW_OPBUF_CE 0
`define ESSC_UW_BRANCH_LO 1
`define ESSC_UW_CNT_EN 5
`define ESSC_UW_PTR8_CE 6
`define ESSC_UW_CNT_LD 7
`define ESSC_UW_GPC_LO 8
`define ESSC_UW_CARRY_CE 11
`define ESSC_UW_OVF_CE 12
`define ESSC_UW_NZ_CE 13
`define ESSC_UW_NZ_SEL_LO 14
`define ESSC_UW_CV_SEL_LO 16
`define ESSC_UW_CMUX_DIS 19
`define ESSC_UW_SHIFT_LO 20
`define ESSC_UW_RB_SEL_LO 22

// phase register bits
`define ESSC_PH_ONE 0
`define ESSC_PH_TWO 1
`define ESSC_PH_THREE 2
`define ESSC_PH_END 3
`define ESSC_PH_UCLK 4
`define ESSC_PH_SELECT 5
`define ESSC_PH_PTR8_DATA 6
`define ESSC_PH_LSHIFT 7

// reset values
`define ESSC_RST_UWORD 24'h000000
`define ESSC_RST_COUNT 8'h00
`define ESSC_RST_WORD 16'h0000

// bus answers one cycle after the request is seen
`define ESSC_WAIT_CYCLES 1

`endif

/* File: logic/essc_pkg.sv */
// Purpose: shared types of the status and step counter block
// Assumes: constants live in essc_regs.svh
// Notes: nothing here is imported
package essc_pkg;

  typedef struct packed {
    logic [1:0] readback_mux_select;
    logic [1:0] shift_reg_select;
    logic carry_mux_disable;
    logic [2:0] carry_ovf_mux_select;
    logic [1:0] neg_zero_mux_select;
    logic neg_zero_clock_enable;
    logic overflow_clock_enable;
    logic carry_clock_enable;
    logic [2:0] general_purpose_code;
    logic count_load_bit;
    logic pointer_bit8_clock_enable;
    logic count_enable_bit;
    logic [3:0] ext_branch_field;
    logic operand_buffer_clock_enable;
  } essc_uword_type;

  typedef struct packed {
    logic neg;
    logic zero;
    logic ovf;
    logic carry;
  } essc_flags_type;

  typedef enum logic [1:0] {
    ESSC_SHIFT_NOP = 2'b00,
    ESSC_SHIFT_RIGHT = 2'b01,
    ESSC_SHIFT_LEFT = 2'b10,
    ESSC_SHIFT_LOAD = 2'b11
  } essc_shift_type;

  typedef enum logic [1:0] {
    ESSC_BUS_IDLE = 2'b00,
    ESSC_BUS_ANSWER = 2'b01
  } essc_bus_state_type;

  typedef struct packed {
    logic left_shift;
    logic ptr8_data;
    logic option_microprogram_select;
    logic microword_clock;
    logic cycle_end;
    logic phase_three;
    logic phase_two;
    logic phase_one;
  } essc_phase_type;

endpackage

/* File: logic/essc_step_counter.sv */
// Purpose: 8-bit up/down step counter with zero detection
// Assumes: load and count strobes come from the same clock domain
// Notes: load is level acting and outranks counting
`timescale 1ns/10ps
`default_nettype none
`include "essc_regs.svh"

module essc_step_counter #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // control
  input wire logic load_i,
  input wire logic count_i,
  input wire logic [WIDTH-1:0] load_value_i,
  // state
  output logic [WIDTH-1:0] count_o,
  output logic zero_o
);

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;

  assign count_o = load_i ? load_value_i : count_q;
  assign zero_o = (count_o[5:0] == 6'h00);

  always_comb
  begin
    count_d = count_q;
    if (load_i)
    begin
      count_d = load_value_i;
    end
    else if (count_i)
    begin
      if (count_q[5])
      begin
        count_d = count_q + WIDTH'(1);
      end
      else
      begin
        count_d = count_q - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      count_q <= `ESSC_RST_COUNT;
    end
    else
    begin
      count_q <= count_d;
    end
  end

endmodule

`default_nettype wire

/* File: logic/essc_flag_mux.sv */
// Purpose: next values for the four option status flags
// Assumes: select codes come from the registered microword
// Notes: purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "essc_regs.svh"

module essc_flag_mux (
  // selects
  input wire logic [1:0] nz_sel_i,
  input wire logic [2:0] cv_sel_i,
  input wire logic carry_mux_disable_i,
  // sources
  input wire logic [15:0] operand_i,
  input wire logic [15:0] shift_i,
  input wire essc_pkg::essc_flags_type flags_i,
  input wire logic left_shift_i,
  // results
  output essc_pkg::essc_flags_type next_o
);

  logic op_zero;
  logic ovf_forecast;

  assign op_zero = (operand_i == `ESSC_RST_WORD);
  assign ovf_forecast = operand_i[15] ^ operand_i[14];

  always_comb
  begin
    next_o = flags_i;
    unique case (nz_sel_i)
      2'h0: begin next_o.neg = flags_i.neg; next_o.zero = flags_i.zero; end
      2'h1: begin next_o.neg = operand_i[15]; next_o.zero = op_zero; end
      2'h2: begin next_o.neg = shift_i[15]; next_o.zero = (shift_i == `ESSC_RST_WORD); end
      2'h3: begin next_o.neg = operand_i[15]; next_o.zero = flags_i.zero & op_zero; end
    endcase
    unique case (cv_sel_i)
      3'h0: begin next_o.carry = flags_i.carry; next_o.ovf = flags_i.ovf; end
      3'h1: begin next_o.carry = operand_i[15]; next_o.ovf = 1'b0; end
      3'h2: begin next_o.carry = operand_i[0]; next_o.ovf = flags_i.ovf; end
      3'h3: begin next_o.carry = 1'b0; next_o.ovf = 1'b0; end
      3'h4: begin next_o.carry = shift_i[15]; next_o.ovf = flags_i.ovf; end
      3'h5: begin next_o.carry = shift_i[0]; next_o.ovf = flags_i.ovf; end
      3'h6: begin next_o.carry = 1'b1; next_o.ovf = flags_i.ovf; end
      3'h7: begin next_o.carry = flags_i.carry; next_o.ovf = 1'b1; end
    endcase
    if (left_shift_i)
    begin
      next_o.ovf = ovf_forecast | flags_i.ovf;
    end
    if (carry_mux_disable_i)
    begin
      next_o.carry = operand_i[15] ^ flags_i.carry;
    end
  end

endmodule

`default_nettype wire

/* File: logic/essc_top.sv */
// Purpose: option status flags, step counter and control microword
// Assumes: Avalon-MM slave, host phases written as a register image
// Notes: four word registers; unmapped reads return zero
//
// Behaviour
// - load step count takes operand buffer bits 7:0
// - count load acts as a level while held
// - active load overrides counting
// - step counter is 8-bit up/down
// - bit 5 set counts up, clear counts down
// - zero indication when low six count bits are zero
// - count clock only with enable and count not zero
// - count enable gated with cycle end pulse
// - count load bit gated with phase one or two
// - all eight count bits exported for branch tests
// - negative, zero, overflow, carry each own flip-flop
// - bit15 xor bit14 sets overflow on left shift, sticky
// - carry clock is enable with phase one or two
// - separate enables for neg/zero pair and overflow
// - 2-bit and 3-bit flag selects; carry mux replaces carry part
// - 24-bit microword captured by microword clock, select gated
// - operand buffer enable gated with phase three
// - pointer bit 8 enable gated with microword clock
// - three-bit general code decoded to strobes
// - shift select picks left, right, load or hold
// - readback select picks source; option select enables drive
// - four-bit branch field offered to host branch mux
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "essc_regs.svh"

module essc_top #(
  parameter int WORD_WIDTH = 16,
  parameter int COUNT_WIDTH = 8
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // avalon-mm slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // status outputs
  output logic [COUNT_WIDTH-1:0] step_count_o,
  output logic step_count_zero_o,
  output essc_pkg::essc_flags_type option_status_flags_o,
  output logic [3:0] ext_branch_field_o,
  output logic [7:0] aux_strobe_o,
  output logic microprogram_pointer_bit8_o,
  // readback bus
  output logic [WORD_WIDTH-1:0] readback_data_o,
  output logic readback_drive_o
);

  typedef struct packed {
    essc_pkg::essc_bus_state_type bus;
    logic [31:0] rdata;
    essc_pkg::essc_uword_type uword;
    essc_pkg::essc_uword_type uword_staged;
    logic [WORD_WIDTH-1:0] operand_buffer;
    logic [WORD_WIDTH-1:0] operand_staged;
    logic [WORD_WIDTH-1:0] shift_data_register;
    essc_pkg::essc_phase_type phase;
    essc_pkg::essc_flags_type flags;
    logic ptr8_ce;
    logic ptr8;
    logic [COUNT_WIDTH-1:0] count_out;
    logic count_zero;
    logic [7:0] strobes;
    logic [WORD_WIDTH-1:0] rb_data;
    logic rb_drive;
  } essc_state_type;

  essc_state_type state_q;
  essc_state_type state_d;
  logic [23:0] uword_image;
  logic load_step_count;
  logic count_clock;
  logic [COUNT_WIDTH-1:0] count_now;
  logic count_zero_now;
  essc_pkg::essc_flags_type flags_next;
  logic carry_flag_clock;
  logic [31:0] wmask;

  function automatic logic [7:0] essc_decode3(input logic [2:0] code);
    essc_decode3 = 8'h01 << code;
  endfunction

  function automatic logic [31:0] essc_lane_mask(input logic [3:0] be);
    essc_lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  assign uword_image = state_q.uword_staged;
  assign wmask = essc_lane_mask(avs_byteenable_i);

  // load holds the counter for as long as the phase level stands
  // load from phases
  assign load_step_count = state_q.uword.count_load_bit
                           & (state_q.phase.phase_one | state_q.phase.phase_two);
  assign count_clock = state_q.uword.count_enable_bit & state_q.phase.cycle_end
                       & ~count_zero_now;
  assign carry_flag_clock = state_q.uword.carry_clock_enable
                            & (state_q.phase.phase_one | state_q.phase.phase_two);

  essc_step_counter #(
    .WIDTH(COUNT_WIDTH)
  ) u_counter (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .load_i(load_step_count),
    .count_i(count_clock),
    .load_value_i(state_q.operand_buffer[COUNT_WIDTH-1:0]),
    .count_o(count_now),
    .zero_o(count_zero_now)
  );

  essc_flag_mux u_flag_mux (
    .nz_sel_i(state_q.uword.neg_zero_mux_select),
    .cv_sel_i(state_q.uword.carry_ovf_mux_select),
    .carry_mux_disable_i(state_q.uword.carry_mux_disable),
    .operand_i(state_q.operand_buffer),
    .shift_i(state_q.shift_data_register),
    .flags_i(state_q.flags),
    .left_shift_i(state_q.phase.left_shift),
    .next_o(flags_next)
  );

  always_comb
  begin
    state_d = state_q;
    state_d.phase.cycle_end = 1'b0;
    state_d.phase.microword_clock = 1'b0;
    // bus slave: one wait cycle, then answer
    unique case (state_q.bus)
      essc_pkg::ESSC_BUS_IDLE:
      begin
        if (avs_read_i | avs_write_i)
        begin
          state_d.bus = essc_pkg::ESSC_BUS_ANSWER;
        end
        // read word latched as the request arrives, stands in the answer cycle
        unique case (avs_address_i)
          `ESSC_OFF_UWORD:
          begin
            state_d.rdata = {8'h00, uword_image};
          end
          `ESSC_OFF_OPBUF:
          begin
            state_d.rdata = {state_q.shift_data_register, state_q.operand_staged};
          end
          `ESSC_OFF_PHASE:
          begin
            state_d.rdata = {24'h000000, state_q.phase};
          end
          `ESSC_OFF_FLAGS:
          begin
            state_d.rdata = {11'h000, state_q.ptr8, state_q.count_zero,
                             3'h0, state_q.flags, state_q.count_out,
                             state_q.rb_data[3:0]};
          end
          default:
          begin
            state_d.rdata = 32'h00000000;
          end
        endcase
      end
      essc_pkg::ESSC_BUS_ANSWER:
      begin
        state_d.bus = essc_pkg::ESSC_BUS_IDLE;
        if (avs_write_i)
        begin
          unique case (avs_address_i)
            `ESSC_OFF_UWORD:
            begin
              state_d.uword_staged = essc_pkg::essc_uword_type'(
                (uword_image & ~wmask[23:0]) | (avs_writedata_i[23:0] & wmask[23:0]));
            end
            `ESSC_OFF_OPBUF:
            begin
              state_d.operand_staged = (state_q.operand_staged & ~wmask[15:0])
                                       | (avs_writedata_i[15:0] & wmask[15:0]);
            end
            `ESSC_OFF_PHASE:
            begin
              if (avs_byteenable_i[0])
              begin
                state_d.phase = essc_pkg::essc_phase_type'(avs_writedata_i[7:0]);
              end
            end
            default:
            begin
              state_d.rdata = state_q.rdata;
            end
          endcase
        end
      end
      default:
      begin
        state_d.bus = essc_pkg::ESSC_BUS_IDLE;
      end
    endcase
    // microword capture, option selected
    // staged word reaches the controls only on the microword clock
    if (state_q.phase.microword_clock & state_q.phase.option_microprogram_select)
    begin
      state_d.uword = state_q.uword_staged;
      state_d.ptr8_ce = state_q.uword_staged.pointer_bit8_clock_enable;
      state_d.strobes = essc_decode3(state_q.uword_staged.general_purpose_code);
    end
    if (!state_q.phase.option_microprogram_select)
    begin
      state_d.strobes = 8'h00;
    end
    if (state_q.phase.microword_clock & state_q.ptr8_ce)
    begin
      state_d.ptr8 = state_q.phase.ptr8_data;
    end
    if (state_q.uword.operand_buffer_clock_enable & state_q.phase.phase_three)
    begin
      state_d.operand_buffer = state_q.operand_staged;
    end
    if (state_q.phase.phase_one | state_q.phase.phase_two)
    begin
      unique case (essc_pkg::essc_shift_type'(state_q.uword.shift_reg_select))
        essc_pkg::ESSC_SHIFT_NOP:
        begin
          state_d.shift_data_register = state_q.shift_data_register;
        end
        essc_pkg::ESSC_SHIFT_RIGHT:
        begin
          state_d.shift_data_register = {state_q.flags.carry,
                                         state_q.shift_data_register[WORD_WIDTH-1:1]};
        end
        essc_pkg::ESSC_SHIFT_LEFT:
        begin
          state_d.shift_data_register = {state_q.shift_data_register[WORD_WIDTH-2:0],
                                         state_q.flags.carry};
        end
        essc_pkg::ESSC_SHIFT_LOAD:
        begin
          state_d.shift_data_register = state_q.operand_buffer;
        end
      endcase
    end
    // carry alone waits for a phase; the other flags follow their enables
    // separate flag flip-flops
    if (state_q.uword.neg_zero_clock_enable)
    begin
      state_d.flags.neg = flags_next.neg;
      state_d.flags.zero = flags_next.zero;
    end
    if (state_q.uword.overflow_clock_enable)
    begin
      state_d.flags.ovf = flags_next.ovf;
    end
    if (carry_flag_clock)
    begin
      state_d.flags.carry = flags_next.carry;
    end
    state_d.count_out = count_now;
    state_d.count_zero = count_zero_now;
    unique case (state_q.uword.readback_mux_select)
      2'h0:
      begin
        state_d.rb_data = state_q.shift_data_register;
      end
      2'h1:
      begin
        state_d.rb_data = state_q.operand_buffer;
      end
      2'h2:
      begin
        state_d.rb_data = WORD_WIDTH'({state_q.flags, count_now});
      end
      2'h3:
      begin
        state_d.rb_data = WORD_WIDTH'({state_q.ptr8, count_zero_now});
      end
    endcase
    // drivers stay off unless the option holds the readback bus
    state_d.rb_drive = state_q.phase.option_microprogram_select;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign avs_readdata_o = state_q.rdata;
  assign avs_waitrequest_o = (state_q.bus == essc_pkg::ESSC_BUS_IDLE);
  assign step_count_o = state_q.count_out;
  assign step_count_zero_o = state_q.count_zero;
  assign option_status_flags_o = state_q.flags;
  assign ext_branch_field_o = state_q.uword.ext_branch_field;
  assign aux_strobe_o = state_q.strobes;
  assign microprogram_pointer_bit8_o = state_q.ptr8;
  assign readback_data_o = state_q.rb_data;
  assign readback_drive_o = state_q.rb_drive;

endmodule

`default_nettype wire

/* File: tb/essc_top_assertions.sv */
// Purpose: port-level checks of the status and step counter block
// Assumes: bound to essc_top from the bench top file
// Notes: one clock domain, synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none

module essc_top_assertions #(
  parameter int COUNT_WIDTH = 8
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // bus
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  // status
  input wire logic [COUNT_WIDTH-1:0] step_count_o,
  input wire logic step_count_zero_o,
  input wire essc_pkg::essc_flags_type option_status_flags_o,
  input wire logic [3:0] ext_branch_field_o,
  input wire logic [7:0] aux_strobe_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  // cycles since the last accepted write
  logic [3:0] idle_q;
  logic [3:0] idle_d;
  always_comb
  begin
    idle_d = idle_q;
    if (avs_write_i && !avs_waitrequest_o)
    begin
      idle_d = 4'h0;
    end
    else if (idle_q != 4'hF)
    begin
      idle_d = idle_q + 4'h1;
    end
  end
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      idle_q <= 4'hF;
    end
    else
    begin
      idle_q <= idle_d;
    end
  end

  sequence bus_taken_s;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence bus_answer_s;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence

  bus_answer_a: assert property (bus_taken_s |=> bus_answer_s)
    else $error("bus answer is not a single wait state");
  bus_idle_a: assert property (!avs_read_i && !avs_write_i && avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest dropped without a request");
  reset_clear_a: assert property ($rose(rst_n_i) |-> step_count_o == '0 && option_status_flags_o == '0)
    else $error("state not cleared by reset");
  zero_track_a: assert property ($stable(step_count_o)[*3] |-> step_count_zero_o == (step_count_o[5:0] == 6'h00))
    else $error("zero indication disagrees with low six count bits");
  ovf_sticky_a: assert property (option_status_flags_o.ovf |=> option_status_flags_o.ovf)
    else $error("overflow flag released");
  count_quiet_a: assert property ($changed(step_count_o) |-> idle_q < 4'h7)
    else $error("count moved without a load or count strobe");
  flag_quiet_a: assert property ($changed(option_status_flags_o) |-> idle_q < 4'h7)
    else $error("flags moved without a flag clock");
  branch_quiet_a: assert property ($changed(ext_branch_field_o) |-> idle_q < 4'h7)
    else $error("branch field moved without a microword clock");
  strobe_onehot_a: assert property ($onehot0(aux_strobe_o))
    else $error("more than one auxiliary strobe");
endmodule

`default_nettype wire

/* File: tb/essc_host_model.sv */
// Purpose: host side that drives the register bus and the phase image
// Assumes: one wait state or more, answered by waitrequest low
// Notes: released write data is inverted so stale values never match
`timescale 1ns/10ps
`default_nettype none
`include "essc_regs.svh"

module essc_host_model (
  // clock
  input wire logic clock_i,
  // avalon-mm master
  output logic [3:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [31:0] avs_writedata_o,
  output logic [3:0] avs_byteenable_o,
  input wire logic [31:0] avs_readdata_i,
  input wire logic avs_waitrequest_i
);
  initial
  begin
    avs_address_o = 4'h0;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = 32'h0;
    avs_byteenable_o = 4'hF;
  end

  task automatic access(input logic wr, input logic [3:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic ok);
    int i;
    ok = 1'b0;
    rdata = 32'h0;
    @(posedge clock_i);
    avs_address_o <= addr;
    avs_writedata_o <= wdata;
    avs_read_o <= !wr;
    avs_write_o <= wr;
    for (i = 0; i < 32; i++)
    begin
      @(posedge clock_i);
      if (avs_waitrequest_i === 1'b0)
      begin
        ok = 1'b1;
        rdata = avs_readdata_i;
        break;
      end
    end
    avs_read_o <= 1'b0;
    avs_write_o <= 1'b0;
    avs_writedata_o <= ~wdata;
  endtask

  task automatic phase(input logic [7:0] bits, output logic ok);
    logic [31:0] unused;
    access(1'b1, `ESSC_OFF_PHASE, {24'h0, bits}, unused, ok);
    repeat (4) @(posedge clock_i);
  endtask
endmodule

`default_nettype wire

/* File: tb/essc_top_tb.sv */
// Purpose: self-checking bench of the status and step counter block
// Assumes: host model issues every bus request
// Notes: option select is kept set during phase writes made by ph; one direct phase write clears it
`timescale 1ns/10ps
`default_nettype none
`include "essc_regs.svh"

module essc_top_tb;
  localparam int COUNT_WIDTH = 8;
  localparam logic [31:0] UW_OPCE = 32'h1 << `ESSC_UW_OPBUF_CE;
  localparam logic [31:0] UW_CNT = (32'h1 << `ESSC_UW_CNT_LD) | (32'h1 << `ESSC_UW_CNT_EN);
  localparam logic [31:0] UW_OVF = 32'h1 << `ESSC_UW_OVF_CE;
  localparam logic [31:0] UW_P8 = 32'h1 << `ESSC_UW_PTR8_CE;
  localparam logic [7:0] PH1 = 8'h01;
  localparam logic [7:0] PH3 = 8'h04;
  localparam logic [7:0] PHEND = 8'h08;
  localparam logic [7:0] PHUCLK = 8'h10;
  localparam logic [7:0] PHP8D = 8'h40;
  localparam logic [7:0] PHLSH = 8'h80;

  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] address;
  logic read;
  logic write;
  logic [31:0] wdata;
  logic [3:0] be;
  logic [31:0] rdata;
  logic wait_req;
  logic [7:0] count;
  logic zero;
  essc_pkg::essc_flags_type flags;
  logic [3:0] branch;
  logic [7:0] strobe;
  logic ptr8;
  logic [15:0] rb_data;
  logic rb_drive;
  int n_errors = 0;
  int cmp_count = 0;

  always #5 clock = ~clock;

  essc_top #(.COUNT_WIDTH(COUNT_WIDTH)) dut (.clock_i(clock), .rst_n_i(rst_n),
    .avs_address_i(address), .avs_read_i(read), .avs_write_i(write), .avs_writedata_i(wdata),
    .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
    .step_count_o(count), .step_count_zero_o(zero), .option_status_flags_o(flags),
    .ext_branch_field_o(branch), .aux_strobe_o(strobe), .microprogram_pointer_bit8_o(ptr8),
    .readback_data_o(rb_data), .readback_drive_o(rb_drive));

  essc_host_model host (.clock_i(clock), .avs_address_o(address), .avs_read_o(read),
    .avs_write_o(write), .avs_writedata_o(wdata), .avs_byteenable_o(be),
    .avs_readdata_i(rdata), .avs_waitrequest_i(wait_req));

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic guard(input logic ok);
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      close_out();
    end
  endtask

  task automatic wr(input logic [3:0] addr, input logic [31:0] data);
    logic [31:0] unused;
    logic ok;
    host.access(1'b1, addr, data, unused, ok);
    guard(ok);
  endtask

  task automatic rd(input logic [3:0] addr, output logic [31:0] data);
    logic ok;
    host.access(1'b0, addr, 32'h0, data, ok);
    guard(ok);
  endtask

  task automatic ph(input logic [7:0] bits);
    logic ok;
    host.phase(bits | 8'h20, ok);
    guard(ok);
  endtask

  task automatic set_uw(input logic [31:0] w);
    wr(`ESSC_OFF_UWORD, w);
    ph(PHUCLK);
  endtask

  task automatic load_count(input logic [15:0] v);
    wr(`ESSC_OFF_OPBUF, {16'h0, v});
    ph(PH3);
    ph(PH1);
    ph(8'h00);
  endtask

  task automatic step_chk(input logic [7:0] exp);
    ph(PHEND);
    chk({24'h0, count}, {24'h0, exp});
    chk({31'h0, zero}, {31'h0, exp[5:0] == 6'h00});
  endtask

  task automatic endt(input string name);
    $display("test %s done", name);
  endtask

  initial
  begin
    logic [31:0] got;
    logic [31:0] uw;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk({24'h0, count}, 32'h0);
    chk({28'h0, flags}, 32'h0);
    endt("reset");
    set_uw(UW_OPCE | UW_CNT);
    wr(`ESSC_OFF_OPBUF, 32'h0000C0FE);
    ph(PH3);
    ph(PH1);
    chk({24'h0, count}, 32'hFE);
    ph(PH1 | PHEND);
    chk({24'h0, count}, 32'hFE);
    ph(8'h00);
    chk({24'h0, count}, 32'hFE);
    endt("load");
    step_chk(8'hFF);
    step_chk(8'h00);
    step_chk(8'h00);
    load_count(16'h0042);
    step_chk(8'h41);
    step_chk(8'h40);
    step_chk(8'h40);
    endt("count");
    set_uw(UW_OPCE | UW_OVF);
    wr(`ESSC_OFF_OPBUF, 32'h00004000);
    ph(PH3);
    chk({31'h0, flags.ovf}, 32'h0);
    ph(PH1 | PHLSH);
    chk({31'h0, flags.ovf}, 32'h1);
    wr(`ESSC_OFF_OPBUF, 32'h0);
    ph(PH3);
    ph(PH1 | PHLSH);
    chk({31'h0, flags.ovf}, 32'h1);
    endt("overflow");
    uw = UW_OPCE | UW_P8 | (32'hA << `ESSC_UW_BRANCH_LO) | (32'h5 << `ESSC_UW_GPC_LO);
    uw = uw | (32'h1 << `ESSC_UW_RB_SEL_LO);
    set_uw(uw);
    rd(`ESSC_OFF_UWORD, got);
    chk(got, uw);
    wr(`ESSC_OFF_OPBUF, 32'h00005A3C);
    ph(PH3);
    ph(PHP8D | PHUCLK);
    chk({28'h0, branch}, 32'hA);
    chk({24'h0, strobe}, 32'h20);
    chk({31'h0, ptr8}, 32'h1);
    chk({16'h0, rb_data}, 32'h5A3C);
    chk({31'h0, rb_drive}, 32'h1);
    wr(`ESSC_OFF_PHASE, 32'h0);
    repeat (4) @(posedge clock);
    chk({31'h0, rb_drive}, 32'h0);
    rd(4'h2, got);
    chk(got, 32'h0);
    endt("microword");
    uw = UW_OPCE | (32'h3 << `ESSC_UW_SHIFT_LO) | (32'h1 << `ESSC_UW_CARRY_CE);
    set_uw(uw | (32'h2 << `ESSC_UW_CV_SEL_LO));
    wr(`ESSC_OFF_OPBUF, 32'h00000001);
    ph(PH3);
    ph(PH1);
    chk({31'h0, flags.carry}, 32'h1);
    rd(`ESSC_OFF_OPBUF, got);
    chk(got, 32'h00010001);
    set_uw(UW_OPCE | (32'h1 << `ESSC_UW_SHIFT_LO));
    ph(PH1);
    repeat (20) @(posedge clock);
    ph(8'h00);
    rd(`ESSC_OFF_OPBUF, got);
    chk(got, 32'hFFFF0001);
    uw = UW_OPCE | (32'h1 << `ESSC_UW_CARRY_CE) | (32'h3 << `ESSC_UW_CV_SEL_LO);
    set_uw(uw | (32'h1 << `ESSC_UW_NZ_CE) | (32'h1 << `ESSC_UW_NZ_SEL_LO));
    wr(`ESSC_OFF_OPBUF, 32'h0);
    ph(PH3);
    ph(PH1);
    chk({28'h0, flags}, 32'h6);
    endt("shift");
    close_out();
  end
endmodule

bind essc_top essc_top_assertions #(.COUNT_WIDTH(COUNT_WIDTH)) u_chk (.clock_i(clock_i),
  .rst_n_i(rst_n_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o), .step_count_o(step_count_o),
  .step_count_zero_o(step_count_zero_o), .option_status_flags_o(option_status_flags_o),
  .ext_branch_field_o(ext_branch_field_o), .aux_strobe_o(aux_strobe_o));

`default_nettype wire
